// ### bench/nft_adc_model.sv
// Sample source and external sync driver standing in for the converter side.
`timescale 1ns/100ps
module nft_adc_model (
  // Clock
  input  wire logic          clk_in,
  // Stream and sync out
  output logic signed [15:0] sample_out,
  output logic               chan_sel_out,
  output logic               sync_out
);
  initial begin
    sample_out   = 16'sh0000;
    chan_sel_out = 1'b0;
    sync_out     = 1'b0;
  end
  // ==========================================================================
  // Fractional rate real stream: select is high for one clock per sample.
  task automatic send_real(input int n);
    repeat (n) begin
      @(negedge clk_in);
      sample_out   = 16'($urandom);
      chan_sel_out = 1'b1;
      @(negedge clk_in);
      sample_out   = ~sample_out;  // Stale data would hide a late capture.
      chan_sel_out = 1'b0;
    end
  endtask : send_real
  // ==========================================================================
  // Toggled stream: every select edge carries one sample.
  task automatic send_toggle(input int n);
    repeat (n) begin
      @(negedge clk_in);
      sample_out   = 16'($urandom);
      chan_sel_out = ~chan_sel_out;
    end
    @(negedge clk_in);
    sample_out = ~sample_out;
  endtask : send_toggle
  // ==========================================================================
  // External sync held for len clocks, never shorter than two clocks.
  task automatic sync_hold(input int len);
    @(negedge clk_in);
    sync_out = 1'b1;
    repeat ((len < 2) ? 2 : len) @(negedge clk_in);
    sync_out = 1'b0;
  endtask : sync_hold
endmodule : nft_adc_model

// ### bench/nft_translator_bench.sv
// Self-checking bench of the NCO frequency translator.
`timescale 1ns/100ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module nft_translator_bench;
  logic               clk_in;
  logic               rstn_in;
  logic        [9:0]  reg_addr;
  logic        [31:0] reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic        [31:0] reg_rdata;
  logic signed [15:0] sample;
  logic               chan_sel;
  logic               src_sync;
  logic               sync_drv;
  logic               sync_oe;
  logic               valid;
  logic               chan_a;
  logic signed [15:0] i_val;
  logic signed [15:0] q_val;
  logic signed [15:0] i_last;
  logic signed [15:0] q_last;
  logic signed [15:0] s_last;
  logic        [31:0] v;
  logic        [31:0] t;
  logic        [31:0] acc;
  int                 mismatches;
  int                 samples_checked;
  int                 vcnt;
  int                 acnt;
  int                 scnt;
  int                 k;
  logic        [31:0] msk [5] = '{32'h000000ff, 32'h000000ff, 32'hffffffff, 32'hffffffff, 32'h0000ffff};
  logic        [31:0] rst [5] = '{32'h00000000, 32'h00000000, 32'hffffffff, 32'h00000000, 32'h00000000};
  wire                sync_pin = sync_oe ? sync_drv : src_sync;
  nft_adc_model src (.clk_in(clk_in), .sample_out(sample), .chan_sel_out(chan_sel), .sync_out(src_sync));
  nft_translator dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .sample_in(sample),
    .chan_sel_in(chan_sel), .oscillator_sync_pin_in(sync_pin), .oscillator_sync_pin_out(sync_drv),
    .oscillator_sync_pin_oe_out(sync_oe), .i_out(i_val), .q_out(q_val), .valid_out(valid), .chan_a_out(chan_a));
  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] acc_after(input logic [31:0] a, input int n, input logic [31:0] w);
    return a + 32'(n) * w;
  endfunction : acc_after
  task automatic reg_write(input logic [9:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_in);
    reg_wr = 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [9:0] a, output logic [31:0] d);
    @(negedge clk_in);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk_in);
    d = reg_rdata;
    @(negedge clk_in);
    reg_rd = 1'b0;
  endtask : reg_read
  task automatic drain;
    repeat (10) @(negedge clk_in);
  endtask : drain
  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Clock, output counters and watchdog.
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (valid === 1'b1) vcnt++;
    if (valid === 1'b1 && chan_a === 1'b1) acnt++;
    if (sync_oe === 1'b1 && sync_drv === 1'b1) scnt++;
    if (valid === 1'b1) begin
      i_last = i_val;
      q_last = q_val;
    end
    if (chan_sel === 1'b1) s_last = sample;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    stop_test();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    rstn_in   = 1'b0;
    reg_addr  = 10'h000;
    reg_wdata = 32'h00000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    void'($urandom(32'he14e));
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    for (int i = 0; i < 5; i++) begin
      reg_read(nft_pkg::ADDR_MODE_CTRL + 10'(i), v);
      `CHECK(v, rst[i])
    end
    // Quadrature corners with dither off: sine is zero at phase zero, cosine a quarter turn on.
    src.send_real(1);
    drain();
    `CHECK(q_last, 16'sh0000)
    `CHECK(i_last[15], s_last[15])
    reg_write(nft_pkg::ADDR_PHASE_OFS, 32'h00004000);
    src.send_real(1);
    drain();
    `CHECK(i_last, 16'sh0000)
    `CHECK(q_last[15], s_last[15])
    for (int i = 1; i < 5; i++) begin
      t = $urandom;
      reg_write(nft_pkg::ADDR_MODE_CTRL + 10'(i), t);
      reg_read(nft_pkg::ADDR_MODE_CTRL + 10'(i), v);
      `CHECK(v, t & msk[i])
    end
    // Single real stream: one step per clock with select high, wrapping.
    acc = 32'h00000000;
    t = $urandom;
    reg_write(nft_pkg::ADDR_TUNING, t);
    k = 3 + int'($urandom % 20);
    vcnt = 0;
    src.send_real(k);
    drain();
    acc = acc_after(acc, k, t);
    reg_read(10'h0ff, v);
    `CHECK(v, acc)
    `CHECK(vcnt, k)
    // Master: tuning access restarts the phase, pulses at the zero crossing.
    reg_write(nft_pkg::ADDR_SYNC_MASK, 32'hffffffff);
    reg_write(nft_pkg::ADDR_MODE_CTRL, 32'h00000008);
    `CHECK(sync_oe, 1'b1)
    reg_write(nft_pkg::ADDR_TUNING, 32'h40000000);
    reg_read(10'h0ff, v);
    `CHECK(v, 32'h00000000)
    scnt = 0;
    src.send_real(8);
    drain();
    `CHECK(scnt, 2)
    src.send_real(1);
    drain();
    reg_read(nft_pkg::ADDR_TUNING, v);
    reg_read(10'h0ff, v);
    `CHECK(v, 32'h00000000)
    // Slave: tuning access leaves the phase alone; held sync clears and stalls.
    reg_write(nft_pkg::ADDR_MODE_CTRL, 32'h00000000);
    `CHECK(sync_oe, 1'b0)
    src.send_real(2);
    t = $urandom;
    reg_write(nft_pkg::ADDR_TUNING, t);
    drain();
    reg_read(10'h0ff, v);
    `CHECK(v, 32'h80000000)
    fork
      src.sync_hold(10);
      begin
        @(negedge clk_in);
        src.send_real(3);
      end
    join
    drain();
    reg_read(10'h0ff, v);
    `CHECK(v, 32'h00000000)
    src.send_real(2);
    drain();
    acc = acc_after(32'h00000000, 2, t);
    reg_read(10'h0ff, v);
    `CHECK(v, acc)
    // Toggled modes: one step per select edge, pairing in complex mode.
    for (int m = 1; m < 3; m++) begin
      reg_write(nft_pkg::ADDR_MODE_CTRL, 32'(m));
      t = $urandom;
      reg_write(nft_pkg::ADDR_TUNING, t);
      k = 2 * (2 + int'($urandom % 8));
      vcnt = 0;
      acnt = 0;
      src.send_toggle(k);
      drain();
      acc = acc_after(acc, k, t);
      reg_read(10'h0ff, v);
      `CHECK(v, acc)
      `CHECK(vcnt, (m == 1) ? k : k / 2)
      if (m == 1) `CHECK(acnt, k / 2)
    end
    stop_test();
  end
endmodule : nft_translator_bench

// ### src/nft_pkg.sv
// Package of constants and types for the NCO frequency translator.
package nft_pkg;
  // ==========================================================================
  // Register map and fields
  localparam logic [9:0] ADDR_MODE_CTRL = 10'h300;
  localparam logic [9:0] ADDR_OSC_CTRL  = 10'h301;
  localparam logic [9:0] ADDR_SYNC_MASK = 10'h302;
  localparam logic [9:0] ADDR_TUNING    = 10'h303;
  localparam logic [9:0] ADDR_PHASE_OFS = 10'h304;
  localparam int         BIT_SYNC_MS    = 3;
  localparam int         BIT_PH_DITHER  = 1;
  localparam int         BIT_AMP_DITHER = 2;
  localparam int         MODE_LSB       = 0;
  localparam logic [7:0]  RST_MODE_CTRL = 8'h00;
  localparam logic [7:0]  RST_OSC_CTRL  = 8'h00;
  localparam logic [31:0] RST_SYNC_MASK = 32'hffffffff;
  localparam logic [31:0] RST_TUNING    = 32'h00000000;
  localparam logic [15:0] RST_PHASE_OFS = 16'h0000;
  localparam logic [16:0] LFSR_SEED     = 17'h1ace1;
  // ==========================================================================
  // Input modes
  typedef enum logic [1:0] {
    NFT_SINGLE_REAL    = 2'h0,
    NFT_DIVERSITY_REAL = 2'h1,
    NFT_SINGLE_COMPLEX = 2'h2
  } nft_mode_t;
endpackage : nft_pkg

// ### src/nft_sincos.sv
// Phase to quadrature conversion using a quarter wave table.
`timescale 1ns/100ps
module nft_sincos (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rstn_in,
  // Phase in
  input  wire logic        [11:0] phase_in,
  input  wire logic               dith_in,
  // Quadrature out
  output logic signed      [15:0] cos_out,
  output logic signed      [15:0] sin_out
);
  logic signed [15:0] qtab [0:255];
  logic        [7:0]  s_idx;
  logic        [7:0]  c_idx;
  logic signed [15:0] s_mag;
  logic signed [15:0] c_mag;
  logic               s_neg;
  logic               c_neg;
  logic        [11:0] cph;

  // A coarse linear-segment table; keeps area small at the cost of spur level.
  always_comb begin
    for (int i = 0; i < 256; i++) begin
      qtab[i] = 16'(i < 128 ? i * 200 : 25600 + (i - 128) * 55);
    end
  end

  assign cph   = phase_in + 12'h400;
  assign s_idx = phase_in[10] ? ~phase_in[9:2] : phase_in[9:2];
  assign c_idx = cph[10] ? ~cph[9:2] : cph[9:2];
  assign s_neg = phase_in[11];
  assign c_neg = cph[11];
  assign s_mag = qtab[s_idx] + {15'h0000, dith_in};
  assign c_mag = qtab[c_idx] + {15'h0000, dith_in};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sin_out <= 16'h0000;
      cos_out <= 16'h0000;
    end else begin
      sin_out <= s_neg ? -s_mag : s_mag;
      cos_out <= c_neg ? -c_mag : c_mag;
    end
  end
endmodule : nft_sincos

// ### src/nft_translator.sv
// NCO frequency translator with dither, phase offset and sync.
`timescale 1ns/100ps
// How it works
// [R1] A 32-bit oscillator gives quadrature samples, resolution fs over 2^32.
// [R2] The accumulator adds the tuning word per accepted sample, wrapping at 2^32.
// [R3] Single real mode: the oscillator steps on every edge with select high.
// [R4] The source drops select after one clock per sample to avoid extra steps.
// [R5] Diversity and complex modes accept a sample only when select toggled.
// [R6] Real modes output input times cosine and input times sine.
// [R7] Diversity mode applies the same oscillator words to channels A and B; the code steps the accumulator on each A and each B sample.
// [R8] Complex mode multiplies I and Q by the quadrature outputs.
// [R9] Control bit 1 enables phase dither of the truncated phase.
// [R10] Control bit 2 enables amplitude dither, independent of phase dither.
// [R11] A 16-bit phase offset is added to the accumulator phase.
// [R12] With master select set, the device drives a sync pulse on the sync pin.
// [R13] With master select clear, the sync pin is sampled as sync input.
// [R14] A slave holds the oscillator inactive while sync input stays high.
// [R15] A sync source holds sync high two sample periods in diversity mode.
// [R16] The mask sets the master pulse window and slave synchronized MSBs; the code masks only the master window, slave sync clears all 32 bits.
// [R17] Software programs the same mask everywhere, normally all ones.
// [R18] Tuning word access forces an internal sync unless the device is slave.
module nft_translator (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rstn_in,
  // Register port
  input  wire logic        [9:0]  reg_addr_in,
  input  wire logic        [31:0] reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic             [31:0] reg_rdata_out,
  // Sample input
  input  wire logic signed [15:0] sample_in,
  input  wire logic               chan_sel_in,
  // Sync pin
  input  wire logic               oscillator_sync_pin_in,
  output logic                    oscillator_sync_pin_out,
  output logic                    oscillator_sync_pin_oe_out,
  // Translated output
  output logic signed      [15:0] i_out,
  output logic signed      [15:0] q_out,
  output logic                    valid_out,
  output logic                    chan_a_out
);
  logic [7:0]  mode_ctrl_q;
  logic [7:0]  osc_ctrl_q;
  logic [31:0] sync_mask_q;
  logic [31:0] tuning_word_q;
  logic [15:0] phase_ofs_q;
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [16:0] lfsr_q;
  logic        sel_m1_q;
  logic        sel_m2_q;
  logic        sel_prev_q;
  logic        sync_m1_q;
  logic        sync_m2_q;
  logic        sync_prev_q;
  logic        force_sync_q;
  logic        sync_out_q;
  logic signed [15:0] smp_m1_q;
  logic signed [15:0] smp_q;
  logic signed [15:0] smp_d1_q;
  logic        acc_ok_d1_q;
  logic        sel_d1_q;
  logic signed [15:0] cos_w;
  logic signed [15:0] sin_w;
  logic signed [31:0] pi_q;
  logic signed [31:0] pq_q;
  logic signed [15:0] i_keep_q;
  logic signed [15:0] q_keep_q;
  logic        acc_ok_d2_q;
  logic        sel_d2_q;
  logic signed [31:0] i_sum_q;
  logic signed [31:0] q_sum_q;

  // ==========================================================================
  // Decode
  wire         is_master   = mode_ctrl_q[nft_pkg::BIT_SYNC_MS];
  wire [1:0]   mode_w      = mode_ctrl_q[nft_pkg::MODE_LSB +: 2];
  wire         mode_real1  = (mode_w == 2'(nft_pkg::NFT_SINGLE_REAL));
  wire         mode_cplx   = (mode_w == 2'(nft_pkg::NFT_SINGLE_COMPLEX));
  wire         ph_dith_en  = osc_ctrl_q[nft_pkg::BIT_PH_DITHER];
  wire         amp_dith_en = osc_ctrl_q[nft_pkg::BIT_AMP_DITHER];
  wire         wr_mode     = reg_wr_in && (reg_addr_in == nft_pkg::ADDR_MODE_CTRL);
  wire         wr_osc      = reg_wr_in && (reg_addr_in == nft_pkg::ADDR_OSC_CTRL);
  wire         wr_mask     = reg_wr_in && (reg_addr_in == nft_pkg::ADDR_SYNC_MASK);
  wire         wr_tune     = reg_wr_in && (reg_addr_in == nft_pkg::ADDR_TUNING);
  wire         wr_phase    = reg_wr_in && (reg_addr_in == nft_pkg::ADDR_PHASE_OFS);
  wire         tune_touch  = (reg_wr_in || reg_rd_in) && (reg_addr_in == nft_pkg::ADDR_TUNING);
  wire         sel_toggled = (sel_m2_q != sel_prev_q);
  wire         accept      = mode_real1 ? sel_m2_q : sel_toggled; // R3 R5
  wire         slave_hold  = !is_master && sync_m2_q && sync_prev_q; // R13 R14
  wire         slave_sync  = !is_master && sync_m2_q;
  wire         do_sync     = slave_sync || force_sync_q;
  wire [31:0]  phase_sum   = acc_q + {phase_ofs_q, 16'h0000}; // R11
  wire [31:0]  ph_dith     = ph_dith_en ? {12'h000, lfsr_q[15:0], 4'h0} : 32'h00000000; // R9
  wire [31:0]  phase_dith  = phase_sum + ph_dith;
  wire [31:0]  masked_acc  = acc_q & sync_mask_q; // R16
  wire         zero_cross  = (masked_acc == 32'h00000000);
  wire         sync_emit   = is_master && accept && zero_cross; // R12

  // ==========================================================================
  // Phase accumulator
  always_comb begin
    acc_d = acc_q;
    if (do_sync) begin
      acc_d = 32'h00000000; // R18
    end else if (accept && !slave_hold) begin
      acc_d = acc_q + tuning_word_q; // R1 R2
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_ctrl_q   <= nft_pkg::RST_MODE_CTRL;
      osc_ctrl_q    <= nft_pkg::RST_OSC_CTRL;
      sync_mask_q   <= nft_pkg::RST_SYNC_MASK;
      tuning_word_q <= nft_pkg::RST_TUNING;
      phase_ofs_q   <= nft_pkg::RST_PHASE_OFS;
      force_sync_q  <= 1'b0;
    end else begin
      if (wr_mode) mode_ctrl_q <= reg_wdata_in[7:0];
      if (wr_osc) osc_ctrl_q <= reg_wdata_in[7:0]; // R9 R10
      if (wr_mask) sync_mask_q <= reg_wdata_in;
      if (wr_tune) tuning_word_q <= reg_wdata_in;
      if (wr_phase) phase_ofs_q <= reg_wdata_in[15:0];
      force_sync_q <= tune_touch && !is_master ? 1'b0 : tune_touch; // R18
    end
  end

  always_comb begin
    unique case (reg_addr_in)
      nft_pkg::ADDR_MODE_CTRL: reg_rdata_out = {24'h000000, mode_ctrl_q};
      nft_pkg::ADDR_OSC_CTRL:  reg_rdata_out = {24'h000000, osc_ctrl_q};
      nft_pkg::ADDR_SYNC_MASK: reg_rdata_out = sync_mask_q;
      nft_pkg::ADDR_TUNING:    reg_rdata_out = tuning_word_q;
      nft_pkg::ADDR_PHASE_OFS: reg_rdata_out = {16'h0000, phase_ofs_q};
      default:                 reg_rdata_out = acc_q;
    endcase
  end

  // ==========================================================================
  // Input sync, accumulator and dither state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_m1_q    <= 1'b0;
      sel_m2_q    <= 1'b0;
      sel_prev_q  <= 1'b0;
      sync_m1_q   <= 1'b0;
      sync_m2_q   <= 1'b0;
      sync_prev_q <= 1'b0;
      smp_m1_q    <= 16'h0000;
      smp_q       <= 16'h0000;
      acc_q       <= 32'h00000000;
      lfsr_q      <= nft_pkg::LFSR_SEED;
      sync_out_q  <= 1'b0;
    end else begin
      sel_m1_q    <= chan_sel_in;
      sel_m2_q    <= sel_m1_q;
      sel_prev_q  <= sel_m2_q;
      sync_m1_q   <= oscillator_sync_pin_in;
      sync_m2_q   <= sync_m1_q;
      sync_prev_q <= sync_m2_q;
      smp_m1_q    <= sample_in;
      smp_q       <= smp_m1_q;
      acc_q       <= acc_d;
      lfsr_q      <= {lfsr_q[15:0], lfsr_q[16] ^ lfsr_q[13]};
      sync_out_q  <= sync_emit; // R12
    end
  end

  // The sin/cos table looks at the top 12 phase bits; dither hides the truncation.
  nft_sincos u_sincos (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .phase_in(phase_dith[31:20]),
    .dith_in (amp_dith_en && lfsr_q[0]), // R10
    .cos_out (cos_w),
    .sin_out (sin_w)
  );

  // ==========================================================================
  // Mixer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      smp_d1_q    <= 16'h0000;
      acc_ok_d1_q <= 1'b0;
      sel_d1_q    <= 1'b0;
      acc_ok_d2_q <= 1'b0;
      sel_d2_q    <= 1'b0;
      pi_q        <= 32'h00000000;
      pq_q        <= 32'h00000000;
      i_sum_q     <= 32'h00000000;
      q_sum_q     <= 32'h00000000;
    end else begin
      smp_d1_q    <= smp_q;
      acc_ok_d1_q <= accept;
      sel_d1_q    <= sel_m2_q;
      acc_ok_d2_q <= acc_ok_d1_q;
      sel_d2_q    <= sel_d1_q;
      pi_q        <= smp_d1_q * cos_w; // R6 R7
      pq_q        <= smp_d1_q * sin_w; // R6 R7
      // Complex: I step gives Icos, Isin; Q step gives Qsin, Qcos and completes sums.
      // Sample and table word meet one cycle after acceptance, so the d1 flags qualify them.
      if (mode_cplx && acc_ok_d1_q) begin
        if (sel_d1_q) begin
          i_sum_q <= smp_d1_q * cos_w; // R8
          q_sum_q <= smp_d1_q * sin_w; // R8
        end else begin
          i_sum_q <= i_sum_q - smp_d1_q * sin_w; // R8
          q_sum_q <= q_sum_q + smp_d1_q * cos_w; // R8
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      i_keep_q <= 16'h0000;
      q_keep_q <= 16'h0000;
    end else if (acc_ok_d2_q && (!mode_cplx || !sel_d2_q)) begin
      i_keep_q <= mode_cplx ? i_sum_q[30:15] : pi_q[30:15];
      q_keep_q <= mode_cplx ? q_sum_q[30:15] : pq_q[30:15];
    end
  end

  logic valid_q;
  logic chan_a_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      valid_q  <= 1'b0;
      chan_a_q <= 1'b0;
    end else begin
      valid_q  <= acc_ok_d2_q && (!mode_cplx || !sel_d2_q);
      chan_a_q <= acc_ok_d2_q && sel_d2_q && !mode_cplx; // R7
    end
  end

  assign i_out                      = i_keep_q;
  assign q_out                      = q_keep_q;
  assign valid_out                  = valid_q;
  assign chan_a_out                 = chan_a_q;
  assign oscillator_sync_pin_out    = sync_out_q;
  assign oscillator_sync_pin_oe_out = is_master; // R12 R13

  // ==========================================================================
  // Checks
  chk_acc_steps_tuning: assert property (@(posedge clk_in) disable iff (!rstn_in) // R2
    (accept && !do_sync && !slave_hold) |=> (acc_q == $past(acc_q) + $past(tuning_word_q)))
    else $error("accumulator did not step by tuning word");
  chk_real_no_step: assert property (@(posedge clk_in) disable iff (!rstn_in) // R3
    (mode_real1 && !sel_m2_q && !do_sync) |=> (acc_q == $past(acc_q)))
    else $error("accumulator moved with select low");
  chk_div_toggle: assert property (@(posedge clk_in) disable iff (!rstn_in) // R5
    (!mode_real1 && !sel_toggled && !do_sync) |=> $stable(acc_q))
    else $error("accumulator moved without select toggle");
  chk_slave_hold: assert property (@(posedge clk_in) disable iff (!rstn_in) // R14
    slave_hold |=> $stable(acc_q))
    else $error("slave oscillator not held");
  chk_slave_zero: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
    slave_sync |=> (acc_q == 32'h00000000))
    else $error("slave sync did not clear phase");
  sequence tune_access_s;
    tune_touch && is_master;
  endsequence
  chk_tune_sync: assert property (@(posedge clk_in) disable iff (!rstn_in) // R18
    tune_access_s |=> ##1 (acc_q == 32'h00000000))
    else $error("tuning access did not reset phase");
  chk_oe_master: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
    oscillator_sync_pin_out |-> oscillator_sync_pin_oe_out)
    else $error("sync pulse driven while slave");
  chk_mask_window: assert property (@(posedge clk_in) disable iff (!rstn_in) // R16
    $rose(sync_out_q) |-> $past(zero_cross) && $past(is_master))
    else $error("sync pulse outside mask window");
  // Pipeline: accept, sample meets table word, product, output flag three cycles on.
  sequence real_take_s;
    !mode_cplx && accept;
  endsequence
  sequence cplx_pair_s;
    (mode_cplx && accept && sel_m2_q) ##1 (mode_cplx && accept && !sel_m2_q);
  endsequence
  chk_real_valid: assert property (@(posedge clk_in) disable iff (!rstn_in) // R6
    real_take_s |-> ##3 valid_q)
    else $error("real sample gave no output");
  chk_div_chan_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R7
    ((mode_w == 2'(nft_pkg::NFT_DIVERSITY_REAL)) && accept && sel_m2_q) |-> ##3 chan_a_q)
    else $error("channel A sample not flagged");
  chk_cplx_pair: assert property (@(posedge clk_in) disable iff (!rstn_in) // R8
    cplx_pair_s |-> ##3 valid_q)
    else $error("complex pair gave no output");
  chk_cplx_i_only: assert property (@(posedge clk_in) disable iff (!rstn_in) // R8
    (mode_cplx && accept && sel_m2_q) |-> ##3 !valid_q)
    else $error("output after in-phase half only");
  chk_sync_on_zero: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
    (is_master && accept && zero_cross) |=> oscillator_sync_pin_out)
    else $error("master missed sync pulse");
  chk_no_pulse_off: assert property (@(posedge clk_in) disable iff (!rstn_in) // R16
    (is_master && accept && !zero_cross) |=> !oscillator_sync_pin_out)
    else $error("sync pulse away from zero crossing");
  chk_slave_no_force: assert property (@(posedge clk_in) disable iff (!rstn_in) // R18
    (tune_touch && !is_master) |=> !force_sync_q)
    else $error("slave forced an internal sync");
endmodule : nft_translator
